/* rtl/occ_defines.svh */
// Register map, field positions, reset values and counts of the clock control block.
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

`define OCC_CTRL_ADDR      32'hBF80F000
`define OCC_CTRL_CLR_ADDR  32'hBF80F004
`define OCC_CTRL_SET_ADDR  32'hBF80F008
`define OCC_CTRL_INV_ADDR  32'hBF80F00C
`define OCC_TUNE_ADDR      32'hBF80F010
`define OCC_TUNE_CLR_ADDR  32'hBF80F014
`define OCC_TUNE_SET_ADDR  32'hBF80F018
`define OCC_TUNE_INV_ADDR  32'hBF80F01C
`define OCC_IRQ_FLAG_STATUS_1_ADDR      32'hBF881040
`define OCC_IRQ_ENABLE_CONTROL_1_ADDR      32'hBF881070
`define OCC_IRQ_PRIORITY_CONTROL_8_ADDR      32'hBF881110

`define OCC_ODIV_LSB       27
`define OCC_FAST_RC_DIVIDER_LSB     24
`define OCC_SECONDARY_OSC_READY_BIT    22
`define OCC_PERIPHERAL_BUS_DIVIDER_LSB      19
`define OCC_MULT_LSB       16
`define OCC_CURRENT_SOURCE_SELECT_LSB       12
`define OCC_NEXT_SOURCE_SELECT_LSB       8
`define OCC_LOCK_BIT       7
`define OCC_PLL_LOCK_STATUS_BIT      5
`define OCC_SLEEP_ON_WAIT_ENABLE_BIT      4
`define OCC_CF_BIT         3
`define OCC_SECONDARY_OSC_ENABLE_BIT     1
`define OCC_SOURCE_SWITCH_REQUEST_BIT      0
`define OCC_FAIL_BIT       14
`define OCC_PRIO_LSB       10
`define OCC_SUB_LSB        8

`define OCC_CTRL_WMASK     32'h3F1F079B
`define OCC_CTRL_LOCKED    32'h00000781
`define OCC_TUNE_WMASK     32'h0000003F
`define OCC_IRQ_PRIORITY_CONTROL_8_WMASK     32'h00001F00
`define OCC_FAST_RC_DIVIDER_RST     3'h1

`define OCC_SRC_FRC        3'h0
`define OCC_SRC_FRC_PLL    3'h1
`define OCC_SRC_PRI        3'h2
`define OCC_SRC_PRI_PLL    3'h3
`define OCC_SRC_SEC        3'h4
`define OCC_SRC_LPRC       3'h5

`define OCC_OSC_FRC        2'h0
`define OCC_OSC_PRI        2'h1
`define OCC_OSC_SEC        2'h2
`define OCC_OSC_LPRC       2'h3

`define OCC_SOSC_WARM_CYC  11'h400

`endif

/* rtl/occ_pkg.sv */
// Types shared by the clock control block.
package occ_pkg;

  typedef enum logic [1:0] {
    OCC_OP_WRITE,
    OCC_OP_CLR,
    OCC_OP_SET,
    OCC_OP_INV
  } occ_op_t;

  typedef struct packed {
    logic [2:0] pll_idiv;
    logic [2:0] pll_mult;
    logic [2:0] pll_odiv;
    logic [1:0] pb_div;
    logic [2:0] init_src;
    logic       fail_safe_clock_monitor_en;
  } occ_cfg_t;

  typedef struct packed {
    logic [2:0] cur_src;
    logic       pll_used;
    logic [2:0] pll_idiv;
    logic [2:0] pll_mult;
    logic [2:0] pll_odiv;
    logic [2:0] frc_div;
    logic [1:0] pb_div;
    logic       sleep_en;
    logic       sec_osc_en;
  } occ_clk_cfg_t;

endpackage : occ_pkg

/* rtl/occ_top.sv */
// Oscillator clock control block with APB register slave and clock-fail interrupt.
// How it works
// - four oscillators feed the clock selection
// - PLL output divider and multiplier set by software, input divider from configuration
// - fast RC postscaler chosen by software
// - software requests switch to next source
// - fail monitor detects lost clock, falls back
// - clock fail flag at status bit 14
// - clock fail enable at enable bit 14
// - priority bits 12:10, subpriority bits 9:8
// - control clear, set, invert alias addresses
// - set alias changes only one bits
// - tuning register has clear, set, invert aliases
// - six bit tuning field, rest zero
// - control register holds documented field layout
// - fast RC divider resets to divide two
// - PLL output divider loads configuration at reset
// - secondary ready only when running and stable
`timescale 1ns/1ns
`include "occ_defines.svh"

module occ_top (
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  // Configuration word, held stable from reset onward.
  input  wire occ_pkg::occ_cfg_t     cfg,
  // Oscillator status from the analog side.
  input  wire logic [3:0]            osc_running,
  input  wire logic                  pll_locked,
  // Clock tree control.
  output occ_pkg::occ_clk_cfg_t      clk_cfg,
  output logic [5:0]                 rc_tune_value,
  // Interrupt request and its priority.
  output logic                       clock_fail_irq,
  output logic [2:0]                 clock_fail_irq_priority,
  output logic [1:0]                 clock_fail_irq_subpriority
);

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT,
    SW_DONE
  } occ_sw_state_t;

  // Maps a source code onto the oscillator that drives it.
  function automatic logic [1:0] osc_of(input logic [2:0] src);
    logic [1:0] osc;
    osc = `OCC_OSC_FRC;
    if (src == `OCC_SRC_PRI || src == `OCC_SRC_PRI_PLL) begin
      osc = `OCC_OSC_PRI;
    end else if (src == `OCC_SRC_SEC) begin
      osc = `OCC_OSC_SEC;
    end else if (src == `OCC_SRC_LPRC) begin
      osc = `OCC_OSC_LPRC;
    end
    return osc;
  endfunction : osc_of

  // Tells whether a source code runs through the PLL.
  function automatic logic uses_pll(input logic [2:0] src);
    return (src == `OCC_SRC_FRC_PLL) || (src == `OCC_SRC_PRI_PLL);
  endfunction : uses_pll

  // Tells whether an address falls in the 16-byte group that starts at base.
  function automatic logic in_group(input logic [31:0] addr, input logic [31:0] base);
    return {addr[31:4], 4'h0} == base;
  endfunction : in_group

  // Applies a plain or alias write to the writable bits only.
  function automatic logic [31:0] apply_wr(
    input logic [31:0]      old,
    input logic [31:0]      wd,
    input occ_pkg::occ_op_t op,
    input logic [31:0]      mask
  );
    logic [31:0] nv;
    nv = old;
    case (op)
      occ_pkg::OCC_OP_WRITE: nv = wd;
      occ_pkg::OCC_OP_CLR:   nv = old & ~wd;
      occ_pkg::OCC_OP_SET:   nv = old | wd;
      occ_pkg::OCC_OP_INV:   nv = old ^ wd;
      default:               nv = old;
    endcase
    return (old & ~mask) | (nv & mask);
  endfunction : apply_wr

  // Synchronisers for the oscillator status pins.
  logic [3:0]  osc_s1_reg;
  logic [3:0]  osc_s2_reg;
  logic        lock_s1_reg;
  logic        lock_s2_reg;

  // Registers.
  logic [31:0] ctrl_reg;
  logic [31:0] tune_reg;
  logic        fail_flag_reg;
  logic        fail_en_reg;
  logic [31:0] ipc_reg;
  logic [2:0]  cur_src_reg;
  logic [10:0] warm_cnt_reg;
  logic        sosc_rdy_reg;
  occ_sw_state_t sw_state_reg;
  logic [31:0] prdata_reg;
  logic        err_reg;

  // Decode.
  logic        setup;
  logic        wr_acc;
  logic        hit_ctrl;
  logic        hit_tune;
  logic        hit_ifs;
  logic        hit_iec;
  logic        hit_ipc;
  logic        mapped;
  occ_pkg::occ_op_t op;
  logic [31:0] ctrl_mask;
  logic [31:0] ctrl_rd;
  logic [31:0] rd_word;
  logic [2:0]  next_src;
  logic        cur_alive;
  logic        tgt_ready;
  logic        fail_evt;
  logic        switch_go;

  assign setup  = psel && !penable;
  // Writes to unmapped or misaligned addresses leave every register as it is.
  assign wr_acc = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_reg;
  assign prdata = prdata_reg;

  assign hit_ctrl = in_group(paddr, `OCC_CTRL_ADDR);
  assign hit_tune = in_group(paddr, `OCC_TUNE_ADDR);
  assign hit_ifs  = (paddr == `OCC_IRQ_FLAG_STATUS_1_ADDR);
  assign hit_iec  = (paddr == `OCC_IRQ_ENABLE_CONTROL_1_ADDR);
  assign hit_ipc  = (paddr == `OCC_IRQ_PRIORITY_CONTROL_8_ADDR);
  assign mapped   = (hit_ctrl || hit_tune || hit_ifs || hit_iec || hit_ipc) &&
                    (paddr[1:0] == 2'h0);

  assign op = occ_pkg::occ_op_t'(paddr[3:2]);

  // Locked configuration protects the source selection bits.
  assign ctrl_mask = ctrl_reg[`OCC_LOCK_BIT] ? (`OCC_CTRL_WMASK & ~`OCC_CTRL_LOCKED)
                                             : `OCC_CTRL_WMASK;

  assign next_src = ctrl_reg[`OCC_NEXT_SOURCE_SELECT_LSB +: 3];

  // Oscillators count as running from reset, so the monitor sees no false loss.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      osc_s1_reg <= 4'hF;
      osc_s2_reg <= 4'hF;
    end else begin
      osc_s1_reg <= osc_running;
      osc_s2_reg <= osc_s1_reg;
    end
  end

  // PLL lock reads as unlocked until the pin has been synchronised.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      lock_s1_reg <= pll_locked;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // running status of the current oscillator, readiness of the next source.
  assign cur_alive = osc_s2_reg[osc_of(cur_src_reg)];
  assign tgt_ready = osc_s2_reg[osc_of(next_src)] && (!uses_pll(next_src) || lock_s2_reg);

  // loss of the running oscillator while monitored.
  // A set failure bit parks the monitor until software clears it.
  assign fail_evt = cfg.fail_safe_clock_monitor_en && !cur_alive && !ctrl_reg[`OCC_CF_BIT];

  assign switch_go = (sw_state_reg == SW_WAIT) && tgt_ready && !fail_evt;

  // secondary ready after a stable warm-up.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      warm_cnt_reg <= 11'h000;
      sosc_rdy_reg <= 1'b0;
    end else if (!ctrl_reg[`OCC_SECONDARY_OSC_ENABLE_BIT] || !osc_s2_reg[`OCC_OSC_SEC]) begin
      warm_cnt_reg <= 11'h000;
      sosc_rdy_reg <= 1'b0;
    end else if (warm_cnt_reg == `OCC_SOSC_WARM_CYC) begin
      sosc_rdy_reg <= 1'b1;
    end else begin
      warm_cnt_reg <= warm_cnt_reg + 11'h001;
    end
  end

  // switch sequencer waits for the target clock.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sw_state_reg <= SW_IDLE;
    end else begin
      case (sw_state_reg)
        SW_IDLE: begin
          if (ctrl_reg[`OCC_SOURCE_SWITCH_REQUEST_BIT]) begin
            sw_state_reg <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (fail_evt) begin
            sw_state_reg <= SW_DONE;
          end else if (tgt_ready) begin
            sw_state_reg <= SW_DONE;
          end
        end
        SW_DONE: begin
          sw_state_reg <= SW_IDLE;
        end
        default: begin
          sw_state_reg <= SW_IDLE;
        end
      endcase
    end
  end

  // Current source: switch on request, fast RC after a failure.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cur_src_reg <= cfg.init_src;
    end else if (fail_evt) begin
      // fall back to the fast RC oscillator.
      cur_src_reg <= `OCC_SRC_FRC;
    end else if (switch_go) begin
      cur_src_reg <= next_src;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_reg <= 32'h00000000;
      ctrl_reg[`OCC_ODIV_LSB +: 3]   <= cfg.pll_odiv;
      ctrl_reg[`OCC_FAST_RC_DIVIDER_LSB +: 3] <= `OCC_FAST_RC_DIVIDER_RST;
      ctrl_reg[`OCC_PERIPHERAL_BUS_DIVIDER_LSB +: 2]  <= cfg.pb_div;
      ctrl_reg[`OCC_MULT_LSB +: 3]   <= cfg.pll_mult;
      ctrl_reg[`OCC_NEXT_SOURCE_SELECT_LSB +: 3]   <= cfg.init_src;
    end else begin
      if (wr_acc && hit_ctrl) begin
        // on alias writes, only bits written as one change.
        // whole alias update in this cycle.
        ctrl_reg <= apply_wr(ctrl_reg, pwdata, op, ctrl_mask) |
                    (ctrl_reg & 32'h00000080);
      end
      if (sw_state_reg == SW_DONE) begin
        ctrl_reg[`OCC_SOURCE_SWITCH_REQUEST_BIT] <= 1'b0;
      end
      // failure sets the status bit, over any clear.
      if (fail_evt) begin
        ctrl_reg[`OCC_CF_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tune_reg <= 32'h00000000;
    end else if (wr_acc && hit_tune) begin
      // only the six tuning bits are kept.
      tune_reg <= apply_wr(tune_reg, pwdata, op, `OCC_TUNE_WMASK);
    end
  end

  // sticky clock-fail flag, write one to clear.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fail_flag_reg <= 1'b0;
    end else if (fail_evt) begin
      fail_flag_reg <= 1'b1;
    end else if (wr_acc && hit_ifs && pwdata[`OCC_FAIL_BIT]) begin
      fail_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      fail_en_reg <= 1'b0;
    end else if (wr_acc && hit_iec) begin
      fail_en_reg <= pwdata[`OCC_FAIL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ipc_reg <= 32'h00000000;
    end else if (wr_acc && hit_ipc) begin
      ipc_reg <= pwdata & `OCC_IRQ_PRIORITY_CONTROL_8_WMASK;
    end
  end

  // status fields merged into the readback.
  always_comb begin
    ctrl_rd = ctrl_reg;
    ctrl_rd[`OCC_SECONDARY_OSC_READY_BIT]    = sosc_rdy_reg;
    ctrl_rd[`OCC_CURRENT_SOURCE_SELECT_LSB +: 3]  = cur_src_reg;
    ctrl_rd[`OCC_PLL_LOCK_STATUS_BIT]      = lock_s2_reg;
  end

  // Read mux; alias addresses read as zero.
  always_comb begin
    rd_word = 32'h00000000;
    if (hit_ctrl && paddr[3:2] == 2'h0) begin
      rd_word = ctrl_rd;
    end else if (hit_tune && paddr[3:2] == 2'h0) begin
      rd_word = tune_reg;
    end else if (hit_ifs) begin
      rd_word[`OCC_FAIL_BIT] = fail_flag_reg;
    end else if (hit_iec) begin
      rd_word[`OCC_FAIL_BIT] = fail_en_reg;
    end else if (hit_ipc) begin
      rd_word = ipc_reg;
    end
  end

  // Read data and error are captured in the setup cycle.
  // Refused reads return zero, even when a register group is hit.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prdata_reg <= 32'h00000000;
      err_reg    <= 1'b0;
    end else if (setup) begin
      prdata_reg <= (pwrite || !mapped) ? 32'h00000000 : rd_word;
      err_reg    <= !mapped;
    end
  end

  // request only with flag and enable.
  assign clock_fail_irq = fail_flag_reg && fail_en_reg;
  assign clock_fail_irq_priority    = ipc_reg[`OCC_PRIO_LSB +: 3];
  assign clock_fail_irq_subpriority = ipc_reg[`OCC_SUB_LSB +: 2];

  // PLL settings to the clock tree.
  // fast RC postscaler to the clock tree.
  always_comb begin
    clk_cfg.cur_src    = cur_src_reg;
    clk_cfg.pll_used   = uses_pll(cur_src_reg);
    clk_cfg.pll_idiv   = cfg.pll_idiv;
    clk_cfg.pll_mult   = ctrl_reg[`OCC_MULT_LSB +: 3];
    clk_cfg.pll_odiv   = ctrl_reg[`OCC_ODIV_LSB +: 3];
    clk_cfg.frc_div    = ctrl_reg[`OCC_FAST_RC_DIVIDER_LSB +: 3];
    clk_cfg.pb_div     = ctrl_reg[`OCC_PERIPHERAL_BUS_DIVIDER_LSB +: 2];
    clk_cfg.sleep_en   = ctrl_reg[`OCC_SLEEP_ON_WAIT_ENABLE_BIT];
    clk_cfg.sec_osc_en = ctrl_reg[`OCC_SECONDARY_OSC_ENABLE_BIT];
  end

  assign rc_tune_value = tune_reg[5:0];

endmodule : occ_top

/* tb/occ_top_props.sv */
// Port-level assertions for the clock control block.
`timescale 1ns/1ns
`include "occ_defines.svh"
module occ_top_props (
  // Clock and reset.
  input wire logic                  clock,
  input wire logic                  nrst,
  // APB slave.
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata,
  // Configuration and clock tree.
  input wire occ_pkg::occ_cfg_t     cfg,
  input wire occ_pkg::occ_clk_cfg_t clk_cfg,
  input wire logic [5:0]            rc_tune_value,
  // Interrupt.
  input wire logic                  clock_fail_irq,
  input wire logic [2:0]            clock_fail_irq_priority,
  input wire logic [1:0]            clock_fail_irq_subpriority
);
  logic wr;
  assign wr = psel && penable && pwrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_access_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_misaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access without error");
  a_alias_read_zero: assert property (psel && penable && !pwrite
    && paddr == `OCC_TUNE_SET_ADDR |-> prdata == 32'h0)
    else $error("alias read not zero");
  a_reset_values: assert property ($rose(nrst) |-> clk_cfg.frc_div == 3'h1
    && clk_cfg.pll_odiv == cfg.pll_odiv && clk_cfg.cur_src == cfg.init_src)
    else $error("wrong values after reset");
  a_prio_write: assert property (wr && paddr == `OCC_IRQ_PRIORITY_CONTROL_8_ADDR |=>
    {clock_fail_irq_priority, clock_fail_irq_subpriority} == $past(pwdata[12:8]))
    else $error("priority fields not written");
  a_tune_write: assert property (wr && paddr == `OCC_TUNE_ADDR |=>
    rc_tune_value == $past(pwdata[5:0])) else $error("tuning write lost");
  a_tune_set: assert property (wr && paddr == `OCC_TUNE_SET_ADDR |=>
    rc_tune_value == ($past(rc_tune_value) | $past(pwdata[5:0])))
    else $error("tuning set alias wrong");
  a_tune_clr: assert property (wr && paddr == `OCC_TUNE_CLR_ADDR |=>
    rc_tune_value == ($past(rc_tune_value) & ~$past(pwdata[5:0])))
    else $error("tuning clear alias wrong");
  a_tune_inv: assert property (wr && paddr == `OCC_TUNE_INV_ADDR |=>
    rc_tune_value == ($past(rc_tune_value) ^ $past(pwdata[5:0])))
    else $error("tuning invert alias wrong");
  a_tune_hold: assert property (!(wr && paddr[31:4] == 28'hBF80F01) |=>
    $stable(rc_tune_value)) else $error("tuning changed without write");
  a_irq_masked: assert property (wr && paddr == `OCC_IRQ_ENABLE_CONTROL_1_ADDR && !pwdata[14]
    |=> !clock_fail_irq) else $error("interrupt high while disabled");
  c_irq: cover property ($rose(clock_fail_irq));
  c_switch: cover property ($changed(clk_cfg.cur_src));
  c_err: cover property (pslverr);
endmodule : occ_top_props

bind occ_top occ_top_props i_occ_top_props (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .prdata, .cfg, .clk_cfg, .rc_tune_value, .clock_fail_irq,
  .clock_fail_irq_priority, .clock_fail_irq_subpriority);

/* tb/testbench.sv */
// Self-checking testbench for the clock control block.
`timescale 1ns/1ns
`include "occ_defines.svh"
module testbench;
  logic                  clock = 1'b0;
  logic                  nrst = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [31:0]           paddr = 32'h0;
  logic [31:0]           pwdata = 32'h0;
  logic [3:0]            osc_running = 4'hF;
  logic                  pll_locked = 1'b0;
  occ_pkg::occ_cfg_t     cfg = '{3'h1, 3'h5, 3'h3, 2'h2, 3'h2, 1'b1};
  logic                  pready, pslverr, clock_fail_irq;
  logic [31:0]           prdata, rd, ctl;
  occ_pkg::occ_clk_cfg_t clk_cfg;
  logic [5:0]            rc_tune_value;
  logic [2:0]            clock_fail_irq_priority;
  logic [1:0]            clock_fail_irq_subpriority;
  logic                  err;
  int                    mismatches = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;
  occ_top i_occ_top (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .cfg(cfg), .osc_running(osc_running), .pll_locked(pll_locked),
    .clk_cfg(clk_cfg), .rc_tune_value(rc_tune_value), .clock_fail_irq(clock_fail_irq),
    .clock_fail_irq_priority(clock_fail_irq_priority),
    .clock_fail_irq_subpriority(clock_fail_irq_subpriority));
  always #5 clock = ~clock;
  task give_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task t_reset;
    ctl = {2'h0, cfg.pll_odiv, 3'h1, 3'h0, cfg.pb_div, cfg.pll_mult, 1'h0, cfg.init_src,
      1'h0, cfg.init_src, 8'h00};
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    chk("control", rd, ctl);
    chk("pll out", {20'h0, clk_cfg.pll_used, clk_cfg.pll_idiv, clk_cfg.pll_mult, clk_cfg.pll_odiv,
      clk_cfg.pb_div}, {20'h0, 1'b0, cfg.pll_idiv, cfg.pll_mult, cfg.pll_odiv, cfg.pb_div});
    chk("source out", {29'h0, clk_cfg.cur_src}, {29'h0, cfg.init_src});
    apb(1'b0, `OCC_TUNE_ADDR, 32'h0);
    chk("tuning", rd, 32'h0);
  endtask : t_reset
  task t_tune;
    logic [31:0] ad [5] = '{`OCC_TUNE_ADDR, `OCC_TUNE_SET_ADDR, `OCC_TUNE_CLR_ADDR,
      `OCC_TUNE_INV_ADDR, `OCC_TUNE_INV_ADDR};
    logic [31:0] wd [5] = '{32'hFFFFFFD5, 32'h2A, 32'h0F, 32'h3F, 32'h30};
    logic [31:0] ex [5] = '{32'h15, 32'h3F, 32'h30, 32'h0F, 32'h3F};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ad[i], wd[i]);
      apb(1'b0, `OCC_TUNE_ADDR, 32'h0);
      chk("tuning", rd, ex[i]);
      chk("tune out", {26'h0, rc_tune_value}, ex[i]);
    end
    apb(1'b0, `OCC_TUNE_SET_ADDR, 32'h0);
    chk("alias read", rd, 32'h0);
  endtask : t_tune
  task t_ctrl_alias;
    apb(1'b1, `OCC_CTRL_SET_ADDR, 32'h10);
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    chk("control set", rd, ctl | 32'h10);
    chk("sleep out", {31'h0, clk_cfg.sleep_en}, 32'h1);
    apb(1'b1, `OCC_CTRL_INV_ADDR, 32'h10);
    apb(1'b1, `OCC_CTRL_CLR_ADDR, 32'h07000000);
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    ctl = ctl & 32'hF8FFFFFF;
    chk("control clr inv", rd, ctl);
    chk("divider out", {29'h0, clk_cfg.frc_div}, 32'h0);
  endtask : t_ctrl_alias
  task t_unmapped;
    apb(1'b0, 32'hBF80F020, 32'h0);
    chk("error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 32'hBF80F011, 32'h0);
    chk("misaligned error", {31'h0, err}, 32'h1);
    chk("tune kept", {26'h0, rc_tune_value}, 32'h3F);
  endtask : t_unmapped
  task t_fail_irq;
    int n;
    apb(1'b1, `OCC_IRQ_PRIORITY_CONTROL_8_ADDR, 32'h00001F00);
    chk("priority", {27'h0, clock_fail_irq_priority, clock_fail_irq_subpriority}, 32'h1F);
    apb(1'b1, `OCC_IRQ_ENABLE_CONTROL_1_ADDR, 32'h00004000);
    chk("irq idle", {31'h0, clock_fail_irq}, 32'h0);
    osc_running <= 4'hD;
    n = 0;
    while (clock_fail_irq !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk("irq", {31'h0, clock_fail_irq}, 32'h1);
    chk("fallback", {29'h0, clk_cfg.cur_src}, 32'h0);
    apb(1'b0, `OCC_IRQ_FLAG_STATUS_1_ADDR, 32'h0);
    chk("flag", rd & 32'h4000, 32'h4000);
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    chk("fail bit", rd & 32'h7008, 32'h0008);
    apb(1'b1, `OCC_IRQ_ENABLE_CONTROL_1_ADDR, 32'h0);
    chk("irq masked", {31'h0, clock_fail_irq}, 32'h0);
    apb(1'b1, `OCC_IRQ_ENABLE_CONTROL_1_ADDR, 32'h00004000);
    apb(1'b1, `OCC_IRQ_FLAG_STATUS_1_ADDR, 32'h00004000);
    chk("irq cleared", {31'h0, clock_fail_irq}, 32'h0);
    osc_running <= 4'hF;
  endtask : t_fail_irq
  task t_switch;
    int n;
    apb(1'b1, `OCC_CTRL_CLR_ADDR, 32'h00000700);
    apb(1'b1, `OCC_CTRL_SET_ADDR, 32'h00000401);
    n = 0;
    do begin
      apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
      n++;
    end while (rd[14:12] !== 3'h4 && n < 10);
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    chk("switched", rd & 32'h7701, 32'h4400);
    chk("source out", {29'h0, clk_cfg.cur_src}, 32'h4);
  endtask : t_switch
  task t_sec_ready;
    apb(1'b1, `OCC_CTRL_SET_ADDR, 32'h2);
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    chk("warming", rd & 32'h00400000, 32'h0);
    chk("sec enable out", {31'h0, clk_cfg.sec_osc_en}, 32'h1);
    repeat (1030) @(posedge clock);
    apb(1'b0, `OCC_CTRL_ADDR, 32'h0);
    chk("ready", rd & 32'h00400000, 32'h00400000);
  endtask : t_sec_ready
  task t_mid_reset;
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    chk("irq after reset", {31'h0, clock_fail_irq}, 32'h0);
  endtask : t_mid_reset
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    t_tune;
    t_ctrl_alias;
    t_unmapped;
    t_fail_irq;
    t_switch;
    t_sec_ready;
    t_mid_reset;
    give_verdict;
  end
endmodule : testbench
